// [logic/atr_pkg.sv]
package atr_pkg;
  localparam int unsigned NUM_PINS = 10;
  localparam int unsigned NUM_SIGS = 13;
  localparam int unsigned NUM_DED  = 5;
  localparam int unsigned CLK_MHZ  = 250;
  // Output pulse 50 to 100 ns: aim at the least, rounded up
  localparam int unsigned PULSE_MIN_NS = 50;
  localparam int unsigned PULSE_CYC    = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EDGE_MIN_NS  = 10;
  // Register indices
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_OUT_EN   = 8'h01;
  localparam logic [7:0] REG_SIG_BASE = 8'h02;
  localparam logic [7:0] REG_PRE_CNT  = 8'h10;
  localparam logic [7:0] REG_POST_CNT = 8'h11;
  localparam logic [7:0] REG_STATUS   = 8'h12;
  localparam logic [7:0] REG_PIN_IN   = 8'h13;
  localparam logic [7:0] REG_SCAN_CNT = 8'h14;
  // Control bits
  localparam int unsigned CTRL_PRETRIG = 0;
  localparam int unsigned CTRL_SW_START = 1;
  localparam int unsigned CTRL_SW_STOP = 2;
  // Signal config fields
  localparam int unsigned SIG_SRC_LSB = 0;
  localparam int unsigned SIG_EN_BIT  = 4;
  localparam int unsigned SIG_INV_BIT = 5;
  localparam int unsigned SIG_LVL_BIT = 6;
  // Signal numbering
  localparam int unsigned SIG_START = 0;
  localparam int unsigned SIG_REF   = 1;
  localparam int unsigned SIG_SCAN  = 2;
  localparam logic [31:0] SIG_RST   = 32'h0000_0000;
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_ARM  = 2'b10,
    ST_POST = 2'b11
  } atr_state_e;
endpackage : atr_pkg

// [logic/atr_trigger_pin_routing.sv]
// How it works
// [RL1] Ten two-way function pins carry all external timing control
// [RL2] Each of thirteen timing signals picks any pin as source
// [RL3] Each pin driver enabled alone; pin drives its fixed timing signal
// [RL4] Signals without a pin output go to five dedicated outputs
// [RL5] Per pin edge or level detect; polarity inversion on all signals
// [RL6] External edge pulses last at least 10 ns, no maximum
// [RL7] Outside party must not drive a pin set as output
// [RL8] Posttrigger keeps only after-trigger data; pretrigger keeps both
// [RL9] Start trigger is edge detected, selectable pin and polarity
// [RL10] Pin 0 output pulses 50-100 ns at each acquisition start
// [RL11] All pin drivers off after reset until software enables them
// [RL12] Software command may issue the start trigger
// [RL13] Reference trigger edge detected; begins posttrigger phase
// [RL14] Pretrigger scans counted down; earlier reference edges ignored
// [RL15] At zero reload posttrigger count; after reference acquire then stop
// [RL16] Pin 1 output pulses 50-100 ns at accepted reference trigger
// [RL17] Reference trigger unused in posttriggered mode
// [RL18] Scan counter started by start trigger, stopped by software or count
// [RL19] Pin inputs synchronised before inversion and edge detection
`timescale 1ns/1ps
`default_nettype none
module atr_trigger_pin_routing (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [9:0]  function_pin_i,
  output logic      [9:0]  function_pin_o,
  output logic      [9:0]  function_pin_oe,
  output logic      [4:0]  dedicated_o,
  input  wire logic [12:0] timing_int_i,
  output logic      [12:0] timing_ext_o,
  input  wire logic        scan_tick,
  output logic             acq_active,
  output logic             keep_data
);
  // [RL1] ten pin lanes
  localparam int unsigned NP = atr_pkg::NUM_PINS;
  localparam int unsigned NS = atr_pkg::NUM_SIGS;

  logic [NP-1:0] sync1_r, sync2_r, sync3_r;
  logic [NP-1:0] sync1_nxt, sync2_nxt, sync3_nxt;
  logic [6:0]    sig_cfg_r [NS];
  logic [6:0]    sig_cfg_nxt [NS];
  logic [NP-1:0] oe_r, oe_nxt;
  logic          pretrig_r, pretrig_nxt;
  logic [31:0]   pre_cnt_r, pre_cnt_nxt, post_cnt_r, post_cnt_nxt;
  logic [31:0]   scan_cnt_r, scan_cnt_nxt;
  atr_pkg::atr_state_e st_r, st_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic [NS-1:0] ext_r, ext_nxt;
  logic [NP-1:0] pin_o_r, pin_o_nxt;
  logic [4:0]    ded_r, ded_nxt;
  logic          keep_r, keep_nxt;
  logic [3:0]    p0_cnt_r, p0_cnt_nxt, p1_cnt_r, p1_cnt_nxt;
  logic [4:0]    p0_run_r, p0_run_nxt, p1_run_r, p1_run_nxt;
  logic          acq_r, acq_nxt;
  logic [NS-1:0] sig_evt;
  logic          start_evt, ref_evt, ref_accept, sw_start, sw_stop;

  // Sync chain: first stage read only by second
  // [RL19] input synchroniser
  always_comb begin
    sync1_nxt = function_pin_i;
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
  end

  // [RL2] source select per signal
  // [RL5] polarity and detect mode
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sig
      logic [3:0] src;
      logic       cur, prv;
      assign src = sig_cfg_r[g][atr_pkg::SIG_SRC_LSB +: 4];
      assign cur = (src < 4'(NP)) ? (sync2_r[src] ^ sig_cfg_r[g][atr_pkg::SIG_INV_BIT]) : 1'b0;
      assign prv = (src < 4'(NP)) ? (sync3_r[src] ^ sig_cfg_r[g][atr_pkg::SIG_INV_BIT]) : 1'b0;
      // Edge mode gives one pulse per qualifying edge; level mode passes level
      assign sig_evt[g] = sig_cfg_r[g][atr_pkg::SIG_EN_BIT] &
                          (sig_cfg_r[g][atr_pkg::SIG_LVL_BIT] ? cur : (cur & ~prv));
      // [RL19] one pulse per edge
      edge_once_a: assert property (@(posedge clk) disable iff (!rstn) // [RL19]
        (sig_evt[g] && !sig_cfg_r[g][atr_pkg::SIG_LVL_BIT] && !wr) |=> !sig_evt[g])
        else $error("edge event longer than one cycle");
    end
  endgenerate

  wire ctrl_wr = wr && (addr == atr_pkg::REG_CTRL);
  assign sw_start = ctrl_wr && wdata[atr_pkg::CTRL_SW_START];
  assign sw_stop  = ctrl_wr && wdata[atr_pkg::CTRL_SW_STOP];
  // [RL9] start edge or [RL12] software start
  assign start_evt = sig_evt[atr_pkg::SIG_START] | sw_start;
  assign ref_evt   = sig_evt[atr_pkg::SIG_REF];
  // [RL14] reference accepted only once armed; [RL17] never in posttrigger
  assign ref_accept = ref_evt && (st_r == atr_pkg::ST_ARM);

  // Register file
  always_comb begin
    pretrig_nxt  = pretrig_r;
    oe_nxt       = oe_r;
    pre_cnt_nxt  = pre_cnt_r;
    post_cnt_nxt = post_cnt_r;
    for (int i = 0; i < NS; i++) begin
      sig_cfg_nxt[i] = sig_cfg_r[i];
    end
    rdata_nxt = 32'h0000_0000;
    if (wr) begin
      if (addr == atr_pkg::REG_CTRL) begin
        pretrig_nxt = wdata[atr_pkg::CTRL_PRETRIG];
      end else if (addr == atr_pkg::REG_OUT_EN) begin
        // [RL3] per pin driver enable
        oe_nxt = wdata[NP-1:0];
      end else if (addr == atr_pkg::REG_PRE_CNT) begin
        pre_cnt_nxt = wdata;
      end else if (addr == atr_pkg::REG_POST_CNT) begin
        post_cnt_nxt = wdata;
      end else if (addr >= atr_pkg::REG_SIG_BASE && addr < atr_pkg::REG_SIG_BASE + 8'(NS)) begin
        sig_cfg_nxt[4'(addr - atr_pkg::REG_SIG_BASE)] = wdata[6:0];
      end
    end
    if (rd) begin
      if (addr == atr_pkg::REG_CTRL) begin
        rdata_nxt = {31'h0, pretrig_r};
      end else if (addr == atr_pkg::REG_OUT_EN) begin
        rdata_nxt = {22'h0, oe_r};
      end else if (addr == atr_pkg::REG_PRE_CNT) begin
        rdata_nxt = pre_cnt_r;
      end else if (addr == atr_pkg::REG_POST_CNT) begin
        rdata_nxt = post_cnt_r;
      end else if (addr == atr_pkg::REG_STATUS) begin
        rdata_nxt = {29'h0, keep_r, st_r};
      end else if (addr == atr_pkg::REG_PIN_IN) begin
        rdata_nxt = {22'h0, sync2_r};
      end else if (addr == atr_pkg::REG_SCAN_CNT) begin
        rdata_nxt = scan_cnt_r;
      end else if (addr >= atr_pkg::REG_SIG_BASE && addr < atr_pkg::REG_SIG_BASE + 8'(NS)) begin
        rdata_nxt = {25'h0, sig_cfg_r[4'(addr - atr_pkg::REG_SIG_BASE)]};
      end
    end
  end

  // Acquisition sequencer
  always_comb begin
    st_nxt       = st_r;
    scan_cnt_nxt = scan_cnt_r;
    keep_nxt     = keep_r;
    case (st_r)
      atr_pkg::ST_IDLE: begin
        // [RL18] scan counter starts on start trigger
        if (start_evt) begin
          st_nxt       = pretrig_r ? atr_pkg::ST_PRE : atr_pkg::ST_POST;
          scan_cnt_nxt = pretrig_r ? pre_cnt_r : post_cnt_r;
          // [RL8] posttrigger data only kept after trigger
          keep_nxt     = 1'b1;
        end
      end
      atr_pkg::ST_PRE: begin
        // [RL14] count pretrigger scans
        if (scan_cnt_r == 32'h0) begin
          // [RL15] reload posttrigger count
          st_nxt       = atr_pkg::ST_ARM;
          scan_cnt_nxt = post_cnt_r;
        end else if (scan_tick) begin
          scan_cnt_nxt = scan_cnt_r - 32'h1;
        end
      end
      atr_pkg::ST_ARM: begin
        // [RL13] reference edge begins posttrigger phase
        if (ref_accept) begin
          st_nxt = atr_pkg::ST_POST;
        end
      end
      default: begin
        // [RL15] acquire post count then stop
        if (scan_cnt_r == 32'h0) begin
          st_nxt   = atr_pkg::ST_IDLE;
          keep_nxt = 1'b0;
        end else if (scan_tick) begin
          scan_cnt_nxt = scan_cnt_r - 32'h1;
        end
      end
    endcase
    // [RL18] software stop
    if (sw_stop) begin
      st_nxt   = atr_pkg::ST_IDLE;
      keep_nxt = 1'b0;
    end
    // Registered so the output comes straight from a flip-flop
    acq_nxt = (st_nxt != atr_pkg::ST_IDLE);
  end

  // Output pulses and pin drive
  always_comb begin
    p0_cnt_nxt = (p0_cnt_r != 4'h0) ? p0_cnt_r - 4'h1 : 4'h0;
    p1_cnt_nxt = (p1_cnt_r != 4'h0) ? p1_cnt_r - 4'h1 : 4'h0;
    // [RL10] start marker pulse
    if (st_r == atr_pkg::ST_IDLE && start_evt) begin
      p0_cnt_nxt = 4'(atr_pkg::PULSE_CYC);
    end
    // [RL16] reference marker pulse
    if (ref_accept) begin
      p1_cnt_nxt = 4'(atr_pkg::PULSE_CYC);
    end
    ext_nxt = sig_evt;
    // [RL3] fixed pin to signal mapping
    pin_o_nxt = {timing_int_i[9:2], p1_cnt_nxt != 4'h0, p0_cnt_nxt != 4'h0};
    // [RL4] remaining signals on dedicated outputs
    // Only three signals are left over, so the two top dedicated lines stay low
    ded_nxt = {2'h0, timing_int_i[12:10]};
  end

  // Width check helpers: consecutive high cycles of each marker pin
  // Five bits leave room past the pulse length, so a stretched pulse still shows
  always_comb begin
    p0_run_nxt = pin_o_r[0] ? p0_run_r + 5'h1 : 5'h0;
    p1_run_nxt = pin_o_r[1] ? p1_run_r + 5'h1 : 5'h0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      sync3_r    <= '0;
      // [RL11] drivers off after reset
      oe_r       <= '0;
      pretrig_r  <= 1'b0;
      pre_cnt_r  <= atr_pkg::CNT_RST;
      post_cnt_r <= atr_pkg::CNT_RST;
      scan_cnt_r <= atr_pkg::CNT_RST;
      st_r       <= atr_pkg::ST_IDLE;
      rdata_r    <= 32'h0000_0000;
      ext_r      <= '0;
      pin_o_r    <= '0;
      ded_r      <= '0;
      keep_r     <= 1'b0;
      p0_cnt_r   <= 4'h0;
      p1_cnt_r   <= 4'h0;
      p0_run_r   <= 5'h0;
      p1_run_r   <= 5'h0;
      acq_r      <= 1'b0;
      for (int i = 0; i < NS; i++) begin
        sig_cfg_r[i] <= atr_pkg::SIG_RST[6:0];
      end
    end else begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      sync3_r    <= sync3_nxt;
      oe_r       <= oe_nxt;
      pretrig_r  <= pretrig_nxt;
      pre_cnt_r  <= pre_cnt_nxt;
      post_cnt_r <= post_cnt_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      st_r       <= st_nxt;
      rdata_r    <= rdata_nxt;
      ext_r      <= ext_nxt;
      pin_o_r    <= pin_o_nxt;
      ded_r      <= ded_nxt;
      keep_r     <= keep_nxt;
      p0_cnt_r   <= p0_cnt_nxt;
      p1_cnt_r   <= p1_cnt_nxt;
      p0_run_r   <= p0_run_nxt;
      p1_run_r   <= p1_run_nxt;
      acq_r      <= acq_nxt;
      for (int i = 0; i < NS; i++) begin
        sig_cfg_r[i] <= sig_cfg_nxt[i];
      end
    end
  end

  assign rdata           = rdata_r;
  assign timing_ext_o    = ext_r;
  assign function_pin_o  = pin_o_r;
  // [RL7] device relies on no contention while enabled
  assign function_pin_oe = oe_r;
  assign dedicated_o     = ded_r;
  assign acq_active      = acq_r;
  assign keep_data       = keep_r;

  // Marker pulses, sequencer and pin enable checks
  start_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // [RL10]
    $fell(function_pin_o[0]) |-> p0_run_r == 5'(atr_pkg::PULSE_CYC))
    else $error("start pulse width wrong");
  start_mark_a: assert property (@(posedge clk) disable iff (!rstn) // [RL10]
    (st_r == atr_pkg::ST_IDLE && start_evt) |=> function_pin_o[0])
    else $error("start marker missing");
  ref_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // [RL16]
    ref_accept |=> function_pin_o[1])
    else $error("reference pulse missing");
  ref_width_a: assert property (@(posedge clk) disable iff (!rstn) // [RL16]
    $fell(function_pin_o[1]) |-> p1_run_r == 5'(atr_pkg::PULSE_CYC))
    else $error("reference pulse width wrong");
  ref_ignored_a: assert property (@(posedge clk) disable iff (!rstn) // [RL14]
    (st_r == atr_pkg::ST_PRE) |=> st_r != atr_pkg::ST_POST)
    else $error("reference accepted before count zero");
  post_noref_a: assert property (@(posedge clk) disable iff (!rstn) // [RL17]
    (st_r == atr_pkg::ST_IDLE && start_evt && !pretrig_r && !sw_stop) |=> st_r == atr_pkg::ST_POST)
    else $error("posttrigger did not start");
  pre_reload_a: assert property (@(posedge clk) disable iff (!rstn) // [RL15]
    (st_r == atr_pkg::ST_PRE && scan_cnt_r == 32'h0 && !sw_stop) |=>
    (st_r == atr_pkg::ST_ARM && scan_cnt_r == $past(post_cnt_r)))
    else $error("post count not reloaded");
  sw_stop_a: assert property (@(posedge clk) disable iff (!rstn) // [RL18]
    sw_stop |=> st_r == atr_pkg::ST_IDLE && !keep_data)
    else $error("software stop ignored");
  start_edge_a: assert property (@(posedge clk) disable iff (!rstn) // [RL9]
    (sig_evt[atr_pkg::SIG_START] && !sig_cfg_r[atr_pkg::SIG_START][atr_pkg::SIG_LVL_BIT] &&
     st_r == atr_pkg::ST_IDLE && !sw_stop) |=> acq_active)
    else $error("start edge ignored");
  oe_follow_a: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
    (wr && addr == atr_pkg::REG_OUT_EN) |=> function_pin_oe == $past(wdata[9:0]))
    else $error("pin enable not applied");

  // Reference edges outside the armed state never reload the pin 1 marker
  ref_drop_a: assert property (@(posedge clk) disable iff (!rstn) // [RL14]
    (ref_evt && st_r != atr_pkg::ST_ARM) |=> p1_cnt_r != 4'(atr_pkg::PULSE_CYC))
    else $error("reference edge accepted outside armed state");
  cnt_load_a: assert property (@(posedge clk) disable iff (!rstn) // [RL18]
    (st_r == atr_pkg::ST_IDLE && start_evt && !sw_stop) |=>
    scan_cnt_r == ($past(pretrig_r) ? $past(pre_cnt_r) : $past(post_cnt_r)))
    else $error("scan counter not loaded at start");
  post_stop_a: assert property (@(posedge clk) disable iff (!rstn) // [RL15]
    (st_r == atr_pkg::ST_POST && scan_cnt_r == 32'h0) |=> !acq_active)
    else $error("acquisition did not stop");
  keep_match_a: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
    keep_data == acq_active)
    else $error("data delivery outside acquisition");

  // Output routing
  pin_route_a: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
    1'b1 |=> function_pin_o[9:2] == $past(timing_int_i[9:2]))
    else $error("pin drive not routed");
  ded_route_a: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
    1'b1 |=> dedicated_o == {2'h0, $past(timing_int_i[12:10])})
    else $error("dedicated output not routed");
  ext_route_a: assert property (@(posedge clk) disable iff (!rstn) // [RL5]
    1'b1 |=> timing_ext_o == $past(sig_evt))
    else $error("timing event not routed");
endmodule : atr_trigger_pin_routing
`default_nettype wire

// [tb/atr_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
module atr_pin_src #(
  parameter int unsigned WIDTH_CYC = 3
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [9:0] idle,
  input  wire logic       fire,
  input  wire logic [3:0] sel,
  input  wire logic [9:0] pin_oe,
  output logic      [9:0] ext_o,
  output logic      [9:0] ext_en
);
  logic [3:0] left_r;
  logic [3:0] sel_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_r <= 4'h0;
      sel_r  <= 4'h0;
    end else if (fire) begin
      left_r <= 4'(WIDTH_CYC);
      sel_r  <= sel;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  // Pulse is the inverse of the idle level, so one edge each way
  always_comb begin
    ext_o = idle;
    if (left_r != 4'h0) ext_o[sel_r] = ~idle[sel_r];
  end
  assign ext_en = ~pin_oe;
endmodule : atr_pin_src
`default_nettype wire

// [tb/atr_trigger_pin_routing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module atr_trigger_pin_routing_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [9:0]  pin_i;
  logic [9:0]  pin_o;
  logic [9:0]  pin_oe;
  logic [4:0]  ded_o;
  logic [12:0] tint = 13'h0;
  logic [12:0] text_o;
  logic        scan_tick = 1'b0;
  logic        acq_active;
  logic        keep_data;
  logic [9:0]  idle = 10'h0;
  logic        fire = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  ext_o;
  logic [9:0]  ext_en;
  logic [7:0]  rnd = 8'h26;
  logic [31:0] d;
  int          err_total = 0;
  int          num_checks = 0;
  int          n_p0 = 0;
  int          n_p1 = 0;
  int          n_e0 = 0;
  int          b0, b1, be, k, p;

  always #2 clk = ~clk;
  // Wire level from both drivers' enables
  assign pin_i = (pin_oe & pin_o) | (ext_en & ext_o);
  always @(posedge clk) begin
    n_p0 <= n_p0 + int'(pin_o[0] & pin_oe[0]);
    n_p1 <= n_p1 + int'(pin_o[1] & pin_oe[1]);
    n_e0 <= n_e0 + int'(text_o[0]);
  end

  atr_trigger_pin_routing DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .function_pin_i(pin_i), .function_pin_o(pin_o),
    .function_pin_oe(pin_oe), .dedicated_o(ded_o), .timing_int_i(tint), .timing_ext_o(text_o),
    .scan_tick(scan_tick), .acq_active(acq_active), .keep_data(keep_data));
  atr_pin_src SRC (.clk(clk), .rstn(rstn), .idle(idle), .fire(fire), .sel(sel),
    .pin_oe(pin_oe), .ext_o(ext_o), .ext_en(ext_en));

  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt
  function automatic logic [31:0] cfg(input int pin, input logic inv, input logic lvl);
    return 32'(pin) | (32'h1 << atr_pkg::SIG_EN_BIT) | (32'(inv) << atr_pkg::SIG_INV_BIT)
      | (32'(lvl) << atr_pkg::SIG_LVL_BIT);
  endfunction : cfg
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic pulse(input logic is_fire, input int pin);
    @(posedge clk);
    if (is_fire) fire <= 1'b1;
    else scan_tick <= 1'b1;
    sel <= 4'(pin);
    @(posedge clk);
    fire      <= 1'b0;
    scan_tick <= 1'b0;
  endtask : pulse
  task automatic wait_act(input logic v);
    int i;
    #1;
    for (i = 0; i < 200 && acq_active !== v; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk("acq_active", 32'(acq_active), 32'(v));
    if (acq_active !== v) conclude();
  endtask : wait_act

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("oe after reset", 32'(pin_oe), 32'h0);
    rd_reg(atr_pkg::REG_STATUS, d);
    chk("status", d, 32'h0);
    rd_reg(8'hff, d);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      rnd = nxt(rnd);
      @(posedge clk);
      tint <= {rnd[4:0], nxt(rnd)};
      wr_reg(atr_pkg::REG_OUT_EN, {22'h0, rnd, 2'h0});
      repeat (2) @(posedge clk);
      #1 chk("oe", 32'(pin_oe), {22'h0, rnd, 2'h0});
      chk("pin out", 32'(pin_o & pin_oe), 32'(tint[9:0] & pin_oe));
      chk("dedicated", 32'(ded_o), {29'h0, tint[12:10]});
    end
    $display("test routing done");
    // Nonzero post count keeps each run going until the software stop
    wr_reg(atr_pkg::REG_POST_CNT, 32'h5);
    wr_reg(atr_pkg::REG_OUT_EN, 32'h3);
    wr_reg(atr_pkg::REG_SIG_BASE + 8'(atr_pkg::SIG_REF), cfg(3, 1'b0, 1'b0));
    b0 = n_p0;
    b1 = n_p1;
    wr_reg(atr_pkg::REG_CTRL, 32'h2);
    wait_act(1'b1);
    chk("keep post", 32'(keep_data), 32'h1);
    pulse(1'b1, 3);
    repeat (20) @(posedge clk);
    chk("ref pulse post", 32'(n_p1 - b1), 32'h0);
    chk("start pulse", 32'(n_p0 - b0), 32'(atr_pkg::PULSE_CYC));
    wr_reg(atr_pkg::REG_CTRL, 32'h4);
    wait_act(1'b0);
    $display("test software start done");
    for (k = 0; k < 4; k++) begin
      rnd = nxt(rnd);
      p = 2 + int'(rnd[2:0]);
      @(posedge clk);
      idle <= 10'(rnd[7]) << p;
      repeat (4) @(posedge clk);
      wr_reg(atr_pkg::REG_SIG_BASE + 8'(atr_pkg::SIG_START), cfg(p, rnd[7], 1'b0));
      b0 = n_p0;
      be = n_e0;
      pulse(1'b1, p);
      wait_act(1'b1);
      repeat (20) @(posedge clk);
      chk("start events", 32'(n_e0 - be), 32'h1);
      chk("start pulse ext", 32'(n_p0 - b0), 32'(atr_pkg::PULSE_CYC));
      wr_reg(atr_pkg::REG_CTRL, 32'h4);
      wait_act(1'b0);
      wr_reg(atr_pkg::REG_SIG_BASE + 8'(atr_pkg::SIG_START), 32'h0);
      idle <= 10'h0;
    end
    $display("test external start done");
    wr_reg(atr_pkg::REG_PRE_CNT, 32'h3);
    wr_reg(atr_pkg::REG_POST_CNT, 32'h2);
    wr_reg(atr_pkg::REG_SIG_BASE + 8'(atr_pkg::SIG_REF), cfg(4, 1'b0, 1'b0));
    b1 = n_p1;
    // Mode bit first: a start in the same write still sees the old mode
    wr_reg(atr_pkg::REG_CTRL, 32'h1);
    wr_reg(atr_pkg::REG_CTRL, 32'h3);
    wait_act(1'b1);
    pulse(1'b1, 4);
    repeat (10) @(posedge clk);
    rd_reg(atr_pkg::REG_STATUS, d);
    chk("early ref state", {30'h0, d[1:0]}, 32'h1);
    for (k = 0; k < 3; k++) pulse(1'b0, 0);
    rd_reg(atr_pkg::REG_STATUS, d);
    chk("armed state", {30'h0, d[1:0]}, 32'h2);
    rd_reg(atr_pkg::REG_SCAN_CNT, d);
    chk("reload", d, 32'h2);
    chk("keep pre", 32'(keep_data), 32'h1);
    pulse(1'b1, 4);
    repeat (20) @(posedge clk);
    rd_reg(atr_pkg::REG_STATUS, d);
    chk("post state", {30'h0, d[1:0]}, 32'h3);
    chk("ref pulse", 32'(n_p1 - b1), 32'(atr_pkg::PULSE_CYC));
    pulse(1'b0, 0);
    #1 chk("still running", 32'(acq_active), 32'h1);
    pulse(1'b0, 0);
    wait_act(1'b0);
    $display("test pretrigger done");
    wr_reg(atr_pkg::REG_SIG_BASE + 8'h3, cfg(5, 1'b1, 1'b1));
    idle <= 10'h020;
    repeat (6) @(posedge clk);
    #1 chk("level inv high", 32'(text_o[3]), 32'h0);
    @(posedge clk);
    idle <= 10'h0;
    repeat (6) @(posedge clk);
    #1 chk("level inv low", 32'(text_o[3]), 32'h1);
    $display("test level mode done");
    conclude();
  end
endmodule : atr_trigger_pin_routing_tb
`default_nettype wire
